// ### hw/cafl_counter_flags.v
// Summary of operation
// R1 - hardware sets each module flag on that module's match or capture event
// R2 - a set module flag requests interrupt only when its module enable is set
// R3 - software clears module flags by writing zero; hardware never clears them
// R4 - module flags sit in control register bits 4..0, module n at bit n
// R5 - reserved bits of control and enable registers read indeterminate; this design reads them as zero
// R6 - software never writes one into reserved control or enable bits
// R7 - control register resets to zero except undefined bit 5
// R8 - overflow enable bit n passes or blocks counter n overflow request
// R9 - interrupt enable register resets bits 4..0 to zero
// R10 - five high-byte registers, counter 0 high is main counter high
// R11 - five low-byte registers, counter 0 low is main counter low
// R12 - all counter high and low byte registers reset to zero
// R13 - module flag enable is mode register bit 0, gating that flag
// R14 - hardware set beats a same-cycle software clear
// R15 - interrupt request ORs all enabled module and overflow flags
`timescale 1ns/1ps
`include "cafl_defines.vh"

module cafl_counter_flags #(
  parameter NUM_MODULES = `CAFL_NUM_MODULES
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // register bus
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // module events and external enables
  input wire [4:0] i_module_event,
  input wire [4:0] i_module_flag_irq_enable,
  input wire [4:0] i_counter_overflow_flag,
  // counter values and interrupts
  output wire [39:0] o_counter_high,
  output wire [39:0] o_counter_low,
  output wire [4:0] o_module_event_flag,
  output wire o_counter_array_irq_req,
  output wire o_irq
);

  // --------------------------------------------------------------------
  // address decode helpers
  // --------------------------------------------------------------------
  // counter index of a low-byte address, 7 when none
  function [2:0] low_index;
    input [7:0] a;
    begin
      case (a)
        `CAFL_ADDR_CNT0_LOW: low_index = 3'h0;
        `CAFL_ADDR_CNT1_LOW: low_index = 3'h1;
        `CAFL_ADDR_CNT2_LOW: low_index = 3'h2;
        `CAFL_ADDR_CNT3_LOW: low_index = 3'h3;
        `CAFL_ADDR_CNT4_LOW: low_index = 3'h4;
        default: low_index = 3'h7;
      endcase
    end
  endfunction

  // counter index of a high-byte address, 7 when none
  function [2:0] high_index;
    input [7:0] a;
    begin
      case (a)
        `CAFL_ADDR_CNT0_HIGH: high_index = 3'h0;
        `CAFL_ADDR_CNT1_HIGH: high_index = 3'h1;
        `CAFL_ADDR_CNT2_HIGH: high_index = 3'h2;
        `CAFL_ADDR_CNT3_HIGH: high_index = 3'h3;
        `CAFL_ADDR_CNT4_HIGH: high_index = 3'h4;
        default: high_index = 3'h7;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  reg [4:0] flags_reg;
  reg [4:0] flags_next;
  reg [4:0] irq_en_reg;
  reg [4:0] evt_status_reg;
  reg [4:0] evt_status_next;
  reg [4:0] evt_en_reg;
  reg [7:0] cnt_high_reg [0:4];
  reg [7:0] cnt_low_reg [0:4];
  wire [2:0] wr_low_idx;
  wire [2:0] wr_high_idx;
  wire [2:0] rd_low_idx;
  wire [2:0] rd_high_idx;
  wire wr_ctrl;
  wire wr_evt_clear;
  integer k;

  assign wr_low_idx = low_index(i_addr);
  assign wr_high_idx = high_index(i_addr);
  assign rd_low_idx = wr_low_idx;
  assign rd_high_idx = wr_high_idx;
  assign wr_ctrl = i_wr && (i_addr == `CAFL_ADDR_CONTROL);
  assign wr_evt_clear = i_wr && (i_addr == `CAFL_ADDR_EVT_CLEAR);

  // --------------------------------------------------------------------
  // module event flags
  // --------------------------------------------------------------------
  // software write stores, then hardware events set on top
  always @*
  begin
    flags_next = flags_reg;
    if (wr_ctrl)
      flags_next = i_wdata[`CAFL_FLAG_MSB:`CAFL_FLAG_LSB]; // R3 R4
    flags_next = flags_next | i_module_event; // R1 R14
  end

  // sticky event status, set wins over write-one clear
  always @*
  begin
    evt_status_next = evt_status_reg;
    if (wr_evt_clear)
      evt_status_next = evt_status_reg & ~i_wdata[4:0];
    evt_status_next = evt_status_next | i_module_event;
  end

  // --------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------
  // one-hot counter select of a byte index, gated by the strobe
  function [4:0] onehot_sel;
    input [2:0] idx;
    input stb;
    begin
      case (idx)
        3'h0: onehot_sel = {4'h0, stb};
        3'h1: onehot_sel = {3'h0, stb, 1'h0};
        3'h2: onehot_sel = {2'h0, stb, 2'h0};
        3'h3: onehot_sel = {1'h0, stb, 3'h0};
        3'h4: onehot_sel = {stb, 4'h0};
        default: onehot_sel = 5'h00;
      endcase
    end
  endfunction

  wire wr_irq_en;
  wire wr_evt_en;
  wire [4:0] wr_low_sel;
  wire [4:0] wr_high_sel;

  // strobes for the single-byte registers
  assign wr_irq_en = i_wr && (i_addr == `CAFL_ADDR_IRQ_ENABLE);
  assign wr_evt_en = i_wr && (i_addr == `CAFL_ADDR_EVT_ENABLE);
  // strobes for the counter bytes, at most one bit high
  assign wr_low_sel = onehot_sel(wr_low_idx, i_wr);
  assign wr_high_sel = onehot_sel(wr_high_idx, i_wr);

  // --------------------------------------------------------------------
  // control flags and enables
  // --------------------------------------------------------------------
  // module flags, software store with hardware set on top
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      flags_reg <= `CAFL_RST_FLAGS; // R7
    else
      flags_reg <= flags_next;
  end

  // overflow enables, reserved bits never stored
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      irq_en_reg <= `CAFL_RST_IRQ_ENABLE; // R9
    else if (wr_irq_en)
      irq_en_reg <= i_wdata[`CAFL_FLAG_MSB:`CAFL_FLAG_LSB]; // R8
  end

  // sticky event status
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      evt_status_reg <= `CAFL_RST_EVT;
    else
      evt_status_reg <= evt_status_next;
  end

  // event interrupt enables
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      evt_en_reg <= `CAFL_RST_EVT;
    else if (wr_evt_en)
      evt_en_reg <= i_wdata[4:0];
  end

  // --------------------------------------------------------------------
  // counter byte registers
  // --------------------------------------------------------------------
  integer m;

  // low bytes, counter 0 is the main counter low byte
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      for (k = 0; k < 5; k = k + 1)
      begin
        cnt_low_reg[k] <= `CAFL_RST_COUNTER; // R12
      end
    end
    else
    begin
      for (k = 0; k < 5; k = k + 1)
      begin
        if (wr_low_sel[k])
          cnt_low_reg[k] <= i_wdata; // R11
      end
    end
  end

  // high bytes, counter 0 is the main counter high byte
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      for (m = 0; m < 5; m = m + 1)
      begin
        cnt_high_reg[m] <= `CAFL_RST_COUNTER; // R12
      end
    end
    else
    begin
      for (m = 0; m < 5; m = m + 1)
      begin
        if (wr_high_sel[m])
          cnt_high_reg[m] <= i_wdata; // R10
      end
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  reg [7:0] rdata_next;
  wire rd_hit_ctrl;
  wire rd_hit_irq_en;
  wire rd_hit_status;
  wire rd_hit_evt_en;
  wire [7:0] ctrl_view;
  wire [7:0] irq_en_view;
  wire [7:0] status_view;
  wire [7:0] evt_en_view;

  // register address hits
  assign rd_hit_ctrl = (i_addr == `CAFL_ADDR_CONTROL);
  assign rd_hit_irq_en = (i_addr == `CAFL_ADDR_IRQ_ENABLE);
  assign rd_hit_status = (i_addr == `CAFL_ADDR_EVT_STATUS);
  assign rd_hit_evt_en = (i_addr == `CAFL_ADDR_EVT_ENABLE);

  // byte views, reserved and unbuilt bits read zero
  assign ctrl_view = {3'h0, flags_reg}; // R4 R5
  assign irq_en_view = {3'h0, irq_en_reg}; // R5
  assign status_view = {3'h0, evt_status_reg};
  assign evt_en_view = {3'h0, evt_en_reg};

  // read mux, unmapped and write-only addresses read zero
  always @*
  begin
    rdata_next = 8'h00;
    if (rd_low_idx != 3'h7)
      rdata_next = cnt_low_reg[rd_low_idx]; // R11
    else if (rd_high_idx != 3'h7)
      rdata_next = cnt_high_reg[rd_high_idx]; // R10
    else if (rd_hit_ctrl)
      rdata_next = ctrl_view;
    else if (rd_hit_irq_en)
      rdata_next = irq_en_view;
    else if (rd_hit_status)
      rdata_next = status_view;
    else if (rd_hit_evt_en)
      rdata_next = evt_en_view;
  end

  // read data stands one cycle after the strobe only
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rdata_next;
    else
      o_rdata <= 8'h00;
  end

  // --------------------------------------------------------------------
  // outputs and interrupts
  // --------------------------------------------------------------------
  // low bytes packed, counter n at bits 8n+7..8n
  assign o_counter_low[7:0] = cnt_low_reg[0];
  assign o_counter_low[15:8] = cnt_low_reg[1];
  assign o_counter_low[23:16] = cnt_low_reg[2];
  assign o_counter_low[31:24] = cnt_low_reg[3];
  assign o_counter_low[39:32] = cnt_low_reg[4];
  // high bytes packed the same way
  assign o_counter_high[7:0] = cnt_high_reg[0];
  assign o_counter_high[15:8] = cnt_high_reg[1];
  assign o_counter_high[23:16] = cnt_high_reg[2];
  assign o_counter_high[31:24] = cnt_high_reg[3];
  assign o_counter_high[39:32] = cnt_high_reg[4];

  assign o_module_event_flag = flags_reg;

  wire [4:0] module_irq_src;
  wire [4:0] overflow_irq_src;

  // enabled sources, one bit per module and per counter
  assign module_irq_src = flags_reg & i_module_flag_irq_enable; // R2 R13
  assign overflow_irq_src = i_counter_overflow_flag & irq_en_reg; // R8
  // shared request from every enabled source
  assign o_counter_array_irq_req = |{module_irq_src, overflow_irq_src}; // R15
  // level interrupt from sticky status
  assign o_irq = |(evt_status_reg & evt_en_reg);

endmodule

// ### hw/cafl_defines.vh
`ifndef CAFL_DEFINES_VH
`define CAFL_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CAFL_ADDR_CONTROL 8'hD8
`define CAFL_ADDR_IRQ_ENABLE 8'hE3
`define CAFL_ADDR_CNT1_LOW 8'hE4
`define CAFL_ADDR_CNT2_LOW 8'hE5
`define CAFL_ADDR_CNT3_LOW 8'hE6
`define CAFL_ADDR_CNT4_LOW 8'hE7
`define CAFL_ADDR_CNT0_LOW 8'hE9
`define CAFL_ADDR_CNT1_HIGH 8'hF4
`define CAFL_ADDR_CNT2_HIGH 8'hF5
`define CAFL_ADDR_CNT3_HIGH 8'hF6
`define CAFL_ADDR_CNT4_HIGH 8'hF7
`define CAFL_ADDR_CNT0_HIGH 8'hF9
`define CAFL_ADDR_EVT_STATUS 8'hC0
`define CAFL_ADDR_EVT_CLEAR 8'hC1
`define CAFL_ADDR_EVT_ENABLE 8'hC2

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CAFL_FLAG_MSB 4
`define CAFL_FLAG_LSB 0
`define CAFL_NUM_MODULES 5
`define CAFL_RST_FLAGS 5'h00
`define CAFL_RST_IRQ_ENABLE 5'h00
`define CAFL_RST_COUNTER 8'h00
`define CAFL_RST_EVT 5'h00

`endif

// ### sim/cafl_checker.sv
`timescale 1ns/1ps
module cafl_checker (
  // bus and clock
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // events and results
  input wire [4:0] i_module_event,
  input wire [4:0] i_module_flag_irq_enable,
  input wire [39:0] o_counter_high,
  input wire [39:0] o_counter_low,
  input wire [4:0] o_module_event_flag,
  input wire o_counter_array_irq_req
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire ctl_wr = i_wr && i_addr == 8'hD8;
  chk_event_sets: assert property (|i_module_event |=>
    (o_module_event_flag & $past(i_module_event)) == $past(i_module_event)) else $error("set");
  chk_flag_sticky: assert property (!ctl_wr |=>
    (o_module_event_flag & $past(o_module_event_flag)) == $past(o_module_event_flag))
    else $error("lost");
  chk_ctl_write: assert property (ctl_wr |=> o_module_event_flag ==
    ($past(i_wdata[4:0]) | $past(i_module_event))) else $error("write");
  chk_irq_gate: assert property (|(o_module_event_flag & i_module_flag_irq_enable)
    |-> o_counter_array_irq_req) else $error("irq");
  chk_ctl_read: assert property (i_rd && i_addr == 8'hD8 |=>
    o_rdata == {3'h0, $past(o_module_event_flag)}) else $error("read");
  chk_reset_zero: assert property ($rose(i_rst_n) |->
    o_module_event_flag == 5'h00 && o_counter_low == 40'h0 && o_counter_high == 40'h0)
    else $error("reset");
  chk_low_write: assert property (i_wr && i_addr == 8'hE9 |=>
    o_counter_low[7:0] == $past(i_wdata)) else $error("low");
  chk_high_write: assert property (i_wr && i_addr == 8'hF9 |=>
    o_counter_high[7:0] == $past(i_wdata)) else $error("high");
  cover property (ctl_wr && |i_module_event);
  cover property (o_counter_array_irq_req);
  cover property (i_rd && i_addr == 8'hD8);
endmodule
bind cafl_counter_flags cafl_checker cafl_checker_inst (.*);

// ### sim/cafl_counter_flags_tb.sv
`timescale 1ns/1ps
module cafl_counter_flags_tb;
  reg clk = 0, rst_n = 0, wr = 0, rd = 0;
  reg [7:0] addr = 8'h00, wd = 8'h00;
  reg [4:0] ev = 5'h00, men = 5'h00, ovf = 5'h00;
  wire [7:0] rdata;
  wire [39:0] hi, lo;
  wire [4:0] flg;
  wire req, irq;
  integer fails = 0, compares = 0, i;
  // clock
  always #12.5 clk = ~clk;
  cafl_counter_flags cafl_counter_flags_inst (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_module_event(ev), .i_module_flag_irq_enable(men), .i_counter_overflow_flag(ovf),
    .o_counter_high(hi), .o_counter_low(lo), .o_module_event_flag(flg),
    .o_counter_array_irq_req(req), .o_irq(irq));
  // ----
  // helpers
  // ----
  task chk(input [39:0] got, input [39:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task pulse_ev(input [4:0] e);
    begin
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 5'h00;
      #1;
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_chk(input [7:0] a, input [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  function [7:0] cad(input integer n, input h);
    cad = (n == 0 ? 8'hE9 : 8'hE3 + n[7:0]) + (h ? 8'h10 : 8'h00);
  endfunction
  // ----
  // scenarios
  // ----
  task t_counters;
    for (i = 0; i < 5; i = i + 1)
    begin
      rd_chk(cad(i, 0), 8'h00);
      wr_reg(cad(i, 0), 8'h10 + i[7:0]);
      wr_reg(cad(i, 1), 8'hA0 + i[7:0]);
      rd_chk(cad(i, 1), 8'hA0 + i[7:0]);
    end
    chk(lo, 40'h1413121110);
    chk(hi, 40'hA4A3A2A1A0);
  endtask
  task t_flags;
    rd_chk(8'hD8, 8'h00);
    for (i = 0; i < 5; i = i + 1)
    begin
      pulse_ev(5'h01 << i);
      rd_chk(8'hD8, 8'h01 << i);
      @(posedge clk);
      men <= ~(5'h01 << i);
      #1 chk(req, 1'b0);
      @(posedge clk);
      men <= 5'h01 << i;
      #1 chk(req, 1'b1);
      @(posedge clk);
      ev <= 5'h11;
      wr <= 1'b1;
      addr <= 8'hD8;
      wd <= 8'h00;
      @(posedge clk);
      ev <= 5'h00;
      wr <= 1'b0;
      #1 chk(flg, 5'h11);
      @(posedge clk);
      men <= 5'h00;
      wr_reg(8'hD8, 8'h00);
      chk(flg, 5'h00);
    end
  endtask
  task t_ovf;
    rd_chk(8'hE3, 8'h00);
    for (i = 0; i < 5; i = i + 1)
    begin
      @(posedge clk);
      ovf <= ~(5'h01 << i);
      wr_reg(8'hE3, 8'h01 << i);
      chk(req, 1'b0);
      @(posedge clk);
      ovf <= 5'h01 << i;
      #1 chk(req, 1'b1);
    end
    rd_chk(8'hE3, 8'h10);
  endtask
  task t_evt;
    rd_chk(8'hC0, 8'h1F);
    chk(irq, 1'b0);
    wr_reg(8'hC2, 8'h1B);
    chk(irq, 1'b1);
    wr_reg(8'hC1, 8'h1B);
    chk(irq, 1'b0);
    rd_chk(8'hC0, 8'h04);
    rd_chk(8'h00, 8'h00);
  endtask
  task wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(flg, 5'h00);
    t_counters;
    t_flags;
    t_ovf;
    t_evt;
    wrap_up;
  end
  // watchdog
  initial
  begin
    #100000 fails = fails + 1;
    wrap_up;
  end
endmodule
